/* design/dvsc_pkg.sv */
// Package of constants and carrier types for the DP-to-VGA sink control block
package dvsc_pkg;
   // Register offsets on the sink register port
   localparam logic [19:0] DVSC_OFF_CAP = 20'h0000C;
   localparam logic [19:0] DVSC_OFF_SPEED = 20'h00109;
   localparam logic [19:0] DVSC_OFF_SINK_CNT = 20'h00200;
   localparam logic [19:0] DVSC_OFF_SVC_IRQ = 20'h00201;
   localparam logic [19:0] DVSC_OFF_PORT_STAT = 20'h00204;
   localparam logic [19:0] DVSC_OFF_LANE_ALIGN = 20'h00204;
   // One-hot speed codes
   localparam logic [7:0] DVSC_SPD_1K = 8'h01;
   localparam logic [7:0] DVSC_SPD_3K = 8'h02;
   localparam logic [7:0] DVSC_SPD_10K = 8'h04;
   localparam logic [7:0] DVSC_SPD_100K = 8'h08;
   localparam logic [7:0] DVSC_SPD_50K = 8'h80;
   // Capability byte: 1, 3, 10, 100 kbit/s plus 50 kbit/s
   localparam logic [7:0] DVSC_CAP_RESET = 8'h8F;
   // Bit of the status byte at 00204h that flags a port status change
   localparam int DVSC_PORT_CHG_BIT = 6;
   // Clock rate and times
   localparam int DVSC_CLK_HZ = 50_000_000;
   localparam int DVSC_INIT_US = 100;
   localparam int DVSC_INIT_CYC = DVSC_INIT_US * (DVSC_CLK_HZ / 1_000_000);
   localparam int DVSC_IRQ_US = 1;
   localparam int DVSC_IRQ_CYC = DVSC_IRQ_US * (DVSC_CLK_HZ / 1_000_000);
   // Half-bit divider counts for each DDC rate
   localparam int DVSC_HB_1K = DVSC_CLK_HZ / 2_000;
   localparam int DVSC_HB_3K = DVSC_CLK_HZ / 6_000;
   localparam int DVSC_HB_10K = DVSC_CLK_HZ / 20_000;
   localparam int DVSC_HB_50K = DVSC_CLK_HZ / 100_000;
   localparam int DVSC_HB_100K = DVSC_CLK_HZ / 200_000;

   typedef enum logic [3:0] {
      DVSC_ST_INIT = 4'b0001,
      DVSC_ST_SETUP = 4'b0010,
      DVSC_ST_RUN = 4'b0100,
      DVSC_ST_IRQ = 4'b1000
   } dvsc_state_e;

   // DDC request from the AUX side
   typedef struct packed {
      logic valid;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
      logic stop;
   } dvsc_ddc_req_s;

   // Reply to the AUX side
   typedef struct packed {
      logic valid;
      logic defer;
      logic ack;
      logic [7:0] rdata;
   } dvsc_ddc_rsp_s;

   // Register port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [19:0] addr;
      logic [7:0] wdata;
   } dvsc_reg_req_s;

   // Video pixel and sync
   typedef struct packed {
      logic hsync;
      logic vsync;
      logic de;
      logic [7:0] red;
      logic [7:0] grn;
      logic [7:0] blu;
   } dvsc_video_s;
endpackage

/* design/dvsc_ddc_master.sv */
// Byte-level I2C master for the DDC bus with a programmable bit rate
`timescale 1ns/1ps
module dvsc_ddc_master
   import dvsc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Half-bit period in cycles
   input wire logic [15:0] half_bit_i,
   // Request: start, address, one byte, optional stop
   input wire logic go_i,
   input wire logic rd_i,
   input wire logic [6:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic stop_i,
   output logic busy_o,
   output logic done_o,
   output logic ack_o,
   output logic [7:0] rdata_o,
   // Open-drain DDC pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_oe_o,
   output logic sda_oe_o
);
   typedef struct packed {
      logic [15:0] div;
      logic [5:0] ph;
      logic busy;
      logic done;
      logic ack;
      logic rd;
      logic stop;
      logic [17:0] sh;
      logic [7:0] rdata;
      logic scl_oe;
      logic sda_oe;
   } dvsc_mst_s;

   dvsc_mst_s q, d;

   // Phases: 0 start, then 18 bits (addr+rw+ack, data+ack) x 2 halves,
   // then stop. Each phase lasts one half bit.
   always_comb
   begin
      logic tick;
      logic [4:0] bit_ix;
      tick = 1'b0;
      bit_ix = 5'h00;
      d = q;
      d.done = 1'b0;
      if (!q.busy)
      begin
         if (go_i)
         begin
            d.busy = 1'b1;
            d.ph = 6'h00;
            d.div = 16'h0000;
            d.rd = rd_i;
            d.stop = stop_i;
            d.sh = {addr_i, rd_i, 1'b1, rd_i ? 8'hFF : wdata_i, 1'b1};
            d.sda_oe = 1'b1;
         end
      end
      else
      begin
         tick = (q.div >= half_bit_i - 16'h0001);
         d.div = tick ? 16'h0000 : q.div + 16'h0001;
         if (tick)
         begin
            d.ph = q.ph + 6'h01;
            bit_ix = q.ph[5:1];
            if (q.ph == 6'h00)
            begin
               // First address bit goes out with the first clock fall
               d.scl_oe = 1'b1;
               d.sda_oe = ~q.sh[17];
            end
            else if (q.ph <= 6'h24)
            begin
               if (q.ph[0])
               begin
                  // Rising clock phase: sample the line
                  d.scl_oe = 1'b0;
                  if (bit_ix == 5'h08)
                     d.ack = ~sda_i;
                  else if (bit_ix >= 5'h09 && bit_ix <= 5'h10)
                     d.rdata = {q.rdata[6:0], sda_i};
                  else if (bit_ix == 5'h11 && !q.rd)
                     d.ack = q.ack & ~sda_i;
               end
               else
               begin
                  // Falling clock phase: present next bit
                  d.scl_oe = 1'b1;
                  d.sda_oe = (q.ph == 6'h24) ? 1'b1 :
                             ~q.sh[17 - bit_ix];
                  if (q.rd && bit_ix == 5'h10 && !q.stop)
                     d.sda_oe = 1'b1;
               end
            end
            else if (q.ph == 6'h25)
            begin
               d.scl_oe = ~q.stop;
               d.sda_oe = q.stop ? 1'b1 : 1'b0;
            end
            else
            begin
               d.sda_oe = 1'b0;
               d.busy = 1'b0;
               d.done = 1'b1;
               if (!q.stop)
                  d.scl_oe = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         q <= '0;
      else
         q <= d;
   end

   assign busy_o = q.busy;
   assign done_o = q.done;
   assign ack_o = q.ack;
   assign rdata_o = q.rdata;
   assign scl_oe_o = q.scl_oe;
   assign sda_oe_o = q.sda_oe;
endmodule // dvsc_ddc_master

/* design/dvsc_top.sv */
// DP-to-VGA sink control: DDC speed, I2C-over-AUX bridge, HPD, blanking
//
// Summary of operation
// - Read-only capability byte marks each DDC bit rate the bridge supports.
// - Source reads capability, writes speed byte; DDC rate follows it.
// - Before any speed write, strap picks 50 or 10 kbit/s.
// - Reading the speed byte returns the one-hot rate in use.
// - Written speed byte masks capability; slowest remaining rate is used.
// - Empty masked result leaves the previous rate unchanged.
// - Bits 0..3 are 1,3,10,100k; 4,5 unsupported; 6 reserved; 7 is 50k.
// - Defer replies answer the source while a DDC transfer runs.
// - Load sense enabled only in vertical blanking, never in line retrace.
// - On connect, update sink status bytes; HPD IRQ after the first.
// - HPD policy taken from strap sampled after initialisation.
// - Strap low: HPD high after init, monitor or not.
// - Strap low: HPD low in init, write sink count, then raise HPD.
// - Strap low: each connect change updates count, sets changed bit, IRQ.
// - Strap high: HPD low until a monitor is detected.
// - Strap high: HPD low whenever the monitor disconnects.
// - Each I2C-over-AUX request becomes a DDC transaction; reply has data.
// - Monitor identification data passes through unchanged, uncached.
// - Incoming video timing is never checked, only passed out.
// - Block outputs RGB with horizontal and vertical sync.
// - Until link is up, syncs low and colours blanked.
// - During init, HPD low, colours disabled, syncs low.
// - Reset and initialisation sequence run on their own from power-on; here reset comes only from rst_i, then init runs alone.
`timescale 1ns/1ps
module dvsc_top
   import dvsc_pkg::*;
#(
   parameter int INIT_CYC = DVSC_INIT_CYC
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Straps
   input wire logic hpd_policy_strap_i,
   input wire logic secondary_config_strap_i,
   input wire logic ddc_speed_strap_i,
   // Sink register port
   input wire dvsc_pkg::dvsc_reg_req_s reg_req_i,
   output dvsc_pkg::dvsc_reg_req_s reg_echo_o,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // I2C-over-AUX request and reply
   input wire dvsc_pkg::dvsc_ddc_req_s ddc_req_i,
   output dvsc_pkg::dvsc_ddc_rsp_s ddc_rsp_o,
   // DDC open-drain pins
   input wire logic ddc_scl_i,
   input wire logic ddc_sda_i,
   output logic ddc_scl_oe_o,
   output logic ddc_sda_oe_o,
   // Video in from link receiver and out to converters
   input wire logic link_up_i,
   input wire dvsc_pkg::dvsc_video_s vid_i,
   output dvsc_pkg::dvsc_video_s vid_o,
   output logic dac_en_o,
   // Load sense and HPD
   input wire logic monitor_present_i,
   output logic sense_en_o,
   output logic hpd_o
);
   import dvsc_pkg::*;

   typedef struct packed {
      dvsc_state_e st;
      logic [31:0] cnt;
      logic policy;
      logic [7:0] speed;
      logic [7:0] sink_cnt;
      logic [7:0] svc_irq;
      logic [7:0] port_stat;
      logic mon;
      logic hpd;
      logic [7:0] rdata;
      logic rvalid;
      dvsc_reg_req_s echo;
      dvsc_ddc_rsp_s rsp;
      logic pend;
      logic ready;
      dvsc_video_s vid;
      logic dac_en;
      logic sense_en;
   } dvsc_top_s;

   dvsc_top_s q, d;

   logic m_busy;
   logic m_done;
   logic m_ack;
   logic [7:0] m_rdata;
   logic m_scl_oe;
   logic m_sda_oe;
   logic [15:0] half_bit;
   logic go;

   ////////////////////////////////////////////////////////////////////////
   // Slowest speed out of a mask: lowest set bit among 0..2, else 50k (bit 7), else 100k (bit 3)
   function automatic logic [7:0] dvsc_slowest(input logic [7:0] m);
      logic [7:0] r;
      r = 8'h00;
      if (m[0])
         r = DVSC_SPD_1K;
      else if (m[1])
         r = DVSC_SPD_3K;
      else if (m[2])
         r = DVSC_SPD_10K;
      else if (m[7])
         r = DVSC_SPD_50K;
      else if (m[3])
         r = DVSC_SPD_100K;
      return r;
   endfunction

   always_comb
   begin
      unique case (1'b1)
         q.speed[0]: half_bit = 16'(DVSC_HB_1K);
         q.speed[1]: half_bit = 16'(DVSC_HB_3K);
         q.speed[2]: half_bit = 16'(DVSC_HB_10K);
         q.speed[7]: half_bit = 16'(DVSC_HB_50K);
         default: half_bit = 16'(DVSC_HB_100K);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [7:0] masked;
      logic mon_now;
      masked = 8'h00;
      mon_now = 1'b0;
      d = q;
      d.rvalid = 1'b0;
      d.echo = reg_req_i;
      d.rsp = '0;
      go = 1'b0;

      // Register port
      if (reg_req_i.rd)
      begin
         d.rvalid = 1'b1;
         unique case (reg_req_i.addr)
            DVSC_OFF_CAP: d.rdata = DVSC_CAP_RESET;
            DVSC_OFF_SPEED: d.rdata = q.speed;
            DVSC_OFF_SINK_CNT: d.rdata = q.sink_cnt;
            DVSC_OFF_SVC_IRQ: d.rdata = q.svc_irq;
            DVSC_OFF_PORT_STAT: d.rdata = q.port_stat;
            default: d.rdata = 8'h00;
         endcase
      end
      if (reg_req_i.wr && reg_req_i.addr == DVSC_OFF_SPEED)
      begin
         masked = reg_req_i.wdata & DVSC_CAP_RESET;
         if (masked != 8'h00)
            d.speed = dvsc_slowest(masked);
         // Otherwise the rate in use stays
      end

      // I2C-over-AUX bridge, identification data passed raw
      // Done is a one-cycle pulse: keep it so a slow retry still finds it
      if (m_done)
         d.ready = 1'b1;
      if (ddc_req_i.valid)
      begin
         d.rsp.valid = 1'b1;
         d.rsp.defer = 1'b1;
         if (q.pend && q.ready)
         begin
            d.rsp.defer = 1'b0;
            d.rsp.ack = m_ack;
            d.rsp.rdata = m_rdata;
            d.pend = 1'b0;
            d.ready = 1'b0;
         end
         else if (!q.pend && !m_busy)
         begin
            go = 1'b1;
            d.pend = 1'b1;
         end
      end

      // Load sense only in vertical blanking, not line retrace
      d.sense_en = q.st != DVSC_ST_INIT && vid_i.vsync
         && ~vid_i.hsync;
      mon_now = q.mon;
      if (q.sense_en)
         mon_now = monitor_present_i;

      // Video: passed untouched once up blanked otherwise
      if (q.st != DVSC_ST_INIT && link_up_i)
      begin
         d.vid = vid_i;
         d.dac_en = 1'b1;
      end
      else
      begin
         d.vid = '0;
         d.dac_en = 1'b0;
      end

      unique case (q.st)
         DVSC_ST_INIT:
         begin
            d.hpd = 1'b0;
            d.cnt = q.cnt + 32'h1;
            if (q.cnt >= 32'(INIT_CYC) - 32'h1)
            begin
               d.policy = hpd_policy_strap_i;
               d.st = DVSC_ST_SETUP;
               d.speed = ddc_speed_strap_i ? DVSC_SPD_50K
                                           : DVSC_SPD_10K;
            end
         end
         DVSC_ST_SETUP:
         begin
            d.mon = monitor_present_i;
            d.sink_cnt = {7'h00, monitor_present_i};
            d.port_stat[0] = monitor_present_i;
            d.st = DVSC_ST_RUN;
         end
         DVSC_ST_RUN:
         begin
            d.hpd = q.policy ? q.mon : 1'b1;
            d.mon = mon_now;
            if (mon_now != q.mon)
            begin
               d.sink_cnt = {7'h00, mon_now};
               d.port_stat[0] = mon_now;
               d.port_stat[DVSC_PORT_CHG_BIT] = 1'b1;
               if (!q.policy)
               begin
                  d.st = DVSC_ST_IRQ;
                  d.cnt = 32'h0;
               end
               else
                  d.hpd = mon_now;
            end
         end
         DVSC_ST_IRQ:
         begin
            // Short low pulse on HPD after status update
            d.hpd = 1'b0;
            d.cnt = q.cnt + 32'h1;
            if (q.cnt >= 32'(DVSC_IRQ_CYC) - 32'h1)
            begin
               d.hpd = 1'b1;
               d.st = DVSC_ST_RUN;
            end
         end
         default: d.st = DVSC_ST_INIT;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.st <= DVSC_ST_INIT;
      end
      else
         q <= d;
   end

   ////////////////////////////////////////////////////////////////////////
   dvsc_ddc_master u_mst (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .half_bit_i(half_bit),
      .go_i(go),
      .rd_i(ddc_req_i.rd),
      .addr_i(ddc_req_i.addr),
      .wdata_i(ddc_req_i.wdata),
      .stop_i(ddc_req_i.stop),
      .busy_o(m_busy),
      .done_o(m_done),
      .ack_o(m_ack),
      .rdata_o(m_rdata),
      .scl_i(ddc_scl_i),
      .sda_i(ddc_sda_i),
      .scl_oe_o(m_scl_oe),
      .sda_oe_o(m_sda_oe)
   );

   assign reg_echo_o = q.echo;
   assign reg_rdata_o = q.rdata;
   assign reg_rvalid_o = q.rvalid;
   assign ddc_rsp_o = q.rsp;
   assign ddc_scl_oe_o = m_scl_oe;
   assign ddc_sda_oe_o = m_sda_oe;
   assign vid_o = q.vid;
   assign dac_en_o = q.dac_en;
   assign sense_en_o = q.sense_en;
   assign hpd_o = q.hpd;

   ////////////////////////////////////////////////////////////////////////
   AST_INIT_HPD_LOW: assert property (@(posedge core_clk_i)
      disable iff (rst_i) q.st == DVSC_ST_INIT |=> !hpd_o && vid_o == '0)
      else $error("hpd or video active in init");
   AST_CAP_READ: assert property (@(posedge core_clk_i)
      disable iff (rst_i) reg_req_i.rd && reg_req_i.addr == DVSC_OFF_CAP
      |=> reg_rdata_o == DVSC_CAP_RESET)
      else $error("capability read wrong");
   AST_SPEED_MASK: assert property (@(posedge core_clk_i)
      disable iff (rst_i) q.st != DVSC_ST_INIT && reg_req_i.wr
      && reg_req_i.addr == DVSC_OFF_SPEED && reg_req_i.wdata == 8'hFF
      |=> q.speed == DVSC_SPD_1K)
      else $error("mask did not pick slowest");
   AST_SPEED_KEEP: assert property (@(posedge core_clk_i)
      disable iff (rst_i) q.st != DVSC_ST_INIT && reg_req_i.wr
      && reg_req_i.addr == DVSC_OFF_SPEED && reg_req_i.wdata == 8'h30
      |=> $stable(q.speed))
      else $error("empty mask changed speed");
   AST_STRAP_SPEED: assert property (@(posedge core_clk_i)
      disable iff (rst_i) q.st == DVSC_ST_INIT ##1 q.st == DVSC_ST_SETUP
      |-> q.speed == ($past(ddc_speed_strap_i) ? DVSC_SPD_50K
                                               : DVSC_SPD_10K))
      else $error("strap speed not applied");
   AST_DEFER_BUSY: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ddc_req_i.valid && m_busy
      |=> ddc_rsp_o.valid && ddc_rsp_o.defer)
      else $error("no defer while busy");
   AST_POLICY_HIGH: assert property (@(posedge core_clk_i)
      disable iff (rst_i) q.st == DVSC_ST_RUN && q.policy && !q.mon
      |-> !hpd_o)
      else $error("hpd high without monitor");
   AST_POLICY_LOW: assert property (@(posedge core_clk_i)
      disable iff (rst_i) q.st == DVSC_ST_RUN && !q.policy
      && $past(q.st) == DVSC_ST_RUN |-> hpd_o)
      else $error("hpd low in run with low strap");
   AST_CHG_BIT: assert property (@(posedge core_clk_i)
      disable iff (rst_i) q.st == DVSC_ST_RUN && !q.policy && q.sense_en
      && monitor_present_i != q.mon
      |=> q.port_stat[DVSC_PORT_CHG_BIT] ##1 !hpd_o)
      else $error("change bit or irq missing");
   AST_BLANK: assert property (@(posedge core_clk_i)
      disable iff (rst_i) !link_up_i |=> vid_o == '0 && !dac_en_o)
      else $error("video not blanked");
   COV_IRQ: cover property (@(posedge core_clk_i) q.st == DVSC_ST_IRQ);
   COV_DONE: cover property (@(posedge core_clk_i) ddc_rsp_o.valid
      && !ddc_rsp_o.defer);
   COV_SPEED: cover property (@(posedge core_clk_i) q.speed == DVSC_SPD_3K);
endmodule // dvsc_top

/* test/dvsc_far_model.sv */
// Far-side model: source retrying I2C-over-AUX and a DDC monitor target
`timescale 1ns/1ps
module dvsc_far_model
   import dvsc_pkg::*;
#(
   parameter logic [6:0] ADDR = 7'h50,
   parameter logic [7:0] WDATA = 8'h5A,
   parameter logic [7:0] RDATA = 8'hA6
)
(
   // Clock and bench command
   input wire logic core_clk_i,
   input wire logic go_i,
   input wire logic rd_i,
   input wire logic [7:0] gap_i,
   output logic done_o,
   output logic [15:0] defers_o,
   output dvsc_pkg::dvsc_ddc_rsp_s last_o,
   // Bridge side
   output dvsc_pkg::dvsc_ddc_req_s req_o,
   input wire dvsc_pkg::dvsc_ddc_rsp_s rsp_i,
   // Monitor side of the DDC lines
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_low_o,
   output logic [6:0] addr_seen_o
);
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   logic rd_q = 1'b0;
   logic [6:0] addr_q = 7'h00;
   int n = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Gap between retries sets a prompt or a slow source
   initial
   begin
      req_o = '0;
      done_o = 1'b0;
      defers_o = '0;
      last_o = '0;
      forever
      begin
         @(posedge core_clk_i iff go_i);
         #1;
         done_o = 1'b0;
         defers_o = '0;
         do
         begin
            req_o = '{1'b1, rd_i, ADDR, WDATA, 1'b1};
            @(posedge core_clk_i);
            #1;
            req_o = '0;
            last_o = rsp_i;
            if (!rsp_i.valid || rsp_i.defer)
            begin
               defers_o++;
               repeat (gap_i + 1) @(posedge core_clk_i);
               #1;
            end
         end while (!last_o.valid || last_o.defer);
         done_o = 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Counts SCL falls from START; acks address and write byte, sends RDATA
   always @(posedge core_clk_i)
   begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (scl_i && scl_q && sda_q && !sda_i)
         n <= 0;
      else if (scl_q && !scl_i)
         n <= n + 1;
      if (!scl_q && scl_i && n == 8)
         rd_q <= sda_i;
      if (!scl_q && scl_i && n >= 1 && n <= 7)
         addr_q <= {addr_q[5:0], sda_i};
   end
   assign addr_seen_o = addr_q;
   assign sda_low_o = (n == 9) || (!rd_q && n == 18)
      || (rd_q && n >= 10 && n <= 17 && !RDATA[17 - n]);
endmodule // dvsc_far_model

/* test/dvsc_top_tb_top.sv */
// Self-checking testbench of the DP-to-VGA sink control block
`timescale 1ns/1ps
module dvsc_top_tb_top;
   import dvsc_pkg::*;
   localparam int INIT = 10;
   localparam logic [7:0] MON_BYTE = 8'hA6;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic pol_s = 1'b0;
   logic spd_s = 1'b1;
   logic link_up = 1'b1;
   logic mon = 1'b0;
   logic go = 1'b0;
   logic rd = 1'b0;
   logic [7:0] gap = 8'h03;
   dvsc_reg_req_s reg_req = '0;
   dvsc_video_s vid_in = '1;
   dvsc_video_s vid_out;
   dvsc_ddc_req_s ddc_req;
   dvsc_ddc_rsp_s ddc_rsp, last;
   logic [7:0] rdata, d;
   logic rvalid, scl_oe, sda_oe, mon_low, dac_en, sense_en, hpd, src_done;
   logic [15:0] defers;
   logic [6:0] addr_seen;
   dvsc_reg_req_s echo;
   wire scl = ~scl_oe;
   wire sda = ~(sda_oe | mon_low);
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;

   always #10 core_clk_i = ~core_clk_i;

   dvsc_top #(.INIT_CYC(INIT)) i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .hpd_policy_strap_i(pol_s), .secondary_config_strap_i(1'b0),
      .ddc_speed_strap_i(spd_s), .reg_req_i(reg_req), .reg_echo_o(echo),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .ddc_req_i(ddc_req),
      .ddc_rsp_o(ddc_rsp), .ddc_scl_i(scl), .ddc_sda_i(sda),
      .ddc_scl_oe_o(scl_oe), .ddc_sda_oe_o(sda_oe), .link_up_i(link_up),
      .vid_i(vid_in), .vid_o(vid_out), .dac_en_o(dac_en),
      .monitor_present_i(mon), .sense_en_o(sense_en), .hpd_o(hpd));

   dvsc_far_model #(.RDATA(MON_BYTE)) i_far (.core_clk_i(core_clk_i),
      .go_i(go), .rd_i(rd), .gap_i(gap), .done_o(src_done),
      .defers_o(defers), .last_o(last), .req_o(ddc_req), .rsp_i(ddc_rsp),
      .scl_i(scl), .sda_i(sda), .sda_low_o(mon_low),
      .addr_seen_o(addr_seen));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step(int k = 1);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask

   task automatic conclude();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic reg_acc(logic wr, logic [19:0] a, logic [7:0] wd);
      reg_req = '{!wr, wr, a, wd};
      step();
      reg_req = '0;
      chk("echo", echo, {!wr, wr, a, wd});
      if (!wr)
         chk("rvalid", rvalid, 1'b1);
      d = rdata;
      step();
   endtask

   task automatic do_reset(logic pol, logic spd);
      rst_i = 1'b1;
      pol_s = pol;
      spd_s = spd;
      step(5);
      rst_i = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_init();
      step(3);
      chk("hpd_init", hpd, 1'b0);
      chk("vid_init", vid_out, '0);
      chk("dac_init", dac_en, 1'b0);
      step(INIT + 4);
      chk("hpd_run", hpd, 1'b1);
      reg_acc(1'b0, DVSC_OFF_SINK_CNT, 8'h00);
      chk("sink_cnt0", d, 8'h00);
      reg_acc(1'b1, DVSC_OFF_CAP, 8'h00);
      reg_acc(1'b0, DVSC_OFF_CAP, 8'h00);
      chk("cap", d, DVSC_CAP_RESET);
      reg_acc(1'b0, DVSC_OFF_SPEED, 8'h00);
      chk("speed_strap", d, DVSC_SPD_50K);
      reg_acc(1'b0, 20'h00300, 8'h00);
      chk("unmapped", d, 8'h00);
      $display("test init done");
   endtask

   task automatic t_speed();
      logic [7:0] wr_v[6] = '{8'hFF, 8'h0C, 8'h30, 8'h40, 8'h82, 8'h08};
      logic [7:0] ex_v[6] = '{8'h01, 8'h04, 8'h04, 8'h04, 8'h02, 8'h08};
      foreach (wr_v[i])
      begin
         reg_acc(1'b1, DVSC_OFF_SPEED, wr_v[i]);
         reg_acc(1'b0, DVSC_OFF_SPEED, 8'h00);
         chk("speed", d, ex_v[i]);
      end
      $display("test speed done");
   endtask

   task automatic ddc_xfer(logic r, logic [7:0] g);
      int t;
      rd = r;
      gap = g;
      go = 1'b1;
      step();
      go = 1'b0;
      step(2);
      for (t = 0; t < 30000 && src_done !== 1'b1; t++)
         step();
      chk("ddc_many_defers", defers > 16'd20, 1'b1);
      chk("ddc_ack", last.ack, 1'b1);
      chk("ddc_addr", addr_seen, 7'h50);
      if (r)
         chk("ddc_rdata", last.rdata, MON_BYTE);
   endtask

   task automatic t_ddc();
      ddc_xfer(1'b1, 8'h03);
      ddc_xfer(1'b0, 8'h28);
      $display("test ddc done");
   endtask

   task automatic t_video();
      // Timing outside any listed mode, passed through as is
      vid_in = '{1'b1, 1'b1, 1'b1, 8'hA5, 8'h3C, 8'h96};
      link_up = 1'b0;
      step(3);
      chk("vid_blank", vid_out, '0);
      link_up = 1'b1;
      step(3);
      chk("vid_pass", vid_out, vid_in);
      $display("test video done");
   endtask

   task automatic irq_pulse(logic present);
      int t;
      int w;
      mon = present;
      for (t = 0; t < 20 && hpd !== 1'b0; t++)
         step();
      for (w = 0; w < 200 && hpd === 1'b0; w++)
         step();
      chk("irq_width", w >= DVSC_IRQ_CYC - 1 && w <= DVSC_IRQ_CYC + 1, 1);
      reg_acc(1'b0, DVSC_OFF_SINK_CNT, 8'h00);
      chk("sink_cnt", d, {7'h00, present});
      reg_acc(1'b0, DVSC_OFF_PORT_STAT, 8'h00);
      chk("port_stat", d, {8'h40 | {7'h00, present}});
   endtask

   task automatic t_detect();
      mon = 1'b1;
      step(20);
      chk("sense_retrace", sense_en, 1'b0);
      chk("hpd_no_sense", hpd, 1'b1);
      mon = 1'b0;
      vid_in.hsync = 1'b0;
      step(3);
      chk("sense_vblank", sense_en, 1'b1);
      irq_pulse(1'b1);
      irq_pulse(1'b0);
      $display("test detect done");
   endtask

   task automatic t_policy_high();
      do_reset(1'b1, 1'b0);
      step(INIT + 6);
      chk("hpd_wait", hpd, 1'b0);
      reg_acc(1'b0, DVSC_OFF_SPEED, 8'h00);
      chk("speed_strap10", d, DVSC_SPD_10K);
      mon = 1'b1;
      step(8);
      chk("hpd_mon", hpd, 1'b1);
      mon = 1'b0;
      step(8);
      chk("hpd_gone", hpd, 1'b0);
      $display("test policy high done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Ceiling well above two DDC transfers at 100 kbit/s plus the short tests
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         error_cnt++;
         conclude();
      end
   end

   initial
   begin
      do_reset(1'b0, 1'b1);
      t_init();
      t_speed();
      t_ddc();
      t_video();
      t_detect();
      t_policy_high();
      conclude();
   end
endmodule // dvsc_top_tb_top
